// ===== core/cfsc_defs.vh
// Purpose: shared constants for the channel fail status and counter bank
// Assumes: 16-bit register data, 5-bit register address
// Notes:   offsets are word indices on the register bank port
`ifndef CFSC_DEFS_VH
`define CFSC_DEFS_VH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define CFSC_ADDR_W         5
`define CFSC_DATA_W         16
`define CFSC_CNT_W          32
`define CFSC_ERR_SRC_N      7

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CFSC_OFS_STATUS     5'h00
`define CFSC_OFS_CNT_LOW    5'h01
`define CFSC_OFS_CNT_HIGH   5'h02
`define CFSC_OFS_STATIC     5'h03
`define CFSC_OFS_DYNAMIC    5'h04

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define CFSC_ST_RELOAD_BIT  7
`define CFSC_ST_ORDER_BIT   6
`define CFSC_ST_OVF_BIT     5
`define CFSC_ST_CLOSE_BIT   4
`define CFSC_ST_FAIL_MSB    3
`define CFSC_ST_FAIL_LSB    0

// ----------------------------------------------------------------------
// error source indices on the toggle input vector
// ----------------------------------------------------------------------
`define CFSC_SRC_RELOAD     0
`define CFSC_SRC_ORDER      1
`define CFSC_SRC_SAME_EDGE  2
`define CFSC_SRC_RES_OVF    3
`define CFSC_SRC_CAL_OVF    4
`define CFSC_SRC_DRV_CLOSE  5
`define CFSC_SRC_CMP_CLOSE  6

// ----------------------------------------------------------------------
// configuration fields and reset values
// ----------------------------------------------------------------------
`define CFSC_DYN_INC_BIT    0
`define CFSC_DYN_MASK_BIT   2
`define CFSC_STATIC_W       4
`define CFSC_RST_STATIC     4'h0
`define CFSC_RST_MASK       1'b0
`define CFSC_RST_CNT        32'h00000000
`define CFSC_RST_DATA       16'h0000

`endif

// ===== core/cfsc_pulse_sync.v
// Purpose: carry one event from the fast edge clock domain as a toggle
// Assumes: source toggles its line once per event, events well spaced
// Notes:   output is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module cfsc_pulse_sync (
    // clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // event toggle from the far domain
    input  wire tgl_async,
    // event pulse in the local domain
    output wire evt_pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // ------------------------------------------------------------------
    // two-flop synchroniser and change detect
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= tgl_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign evt_pulse = sync_q ^ prev_q;
endmodule

// ===== core/cfsc_fail_add.v
// Purpose: count masked fail events of one pattern period
// Assumes: edge and window strobes are one-cycle pulses on clk_sys
// Notes:   yields per-edge fail bits and an increment of 0 to 5
`timescale 1ns/1ps
module cfsc_fail_add (
    // fail strobes, one per edge delay
    input  wire [3:0] edge_fail,
    input  wire [3:0] window_fail,
    input  wire [3:0] pattern_fail_mask,
    input  wire       fail_mask_all,
    input  wire       soft_inc,
    // results
    output wire [3:0] edge_hit,
    output reg  [2:0] inc_amount
);
    integer i;

    // fails blocked per edge by pattern mask or all at once by the dynamic mask bit
    assign edge_hit = (edge_fail | window_fail) & ~pattern_fail_mask
                      & {4{~fail_mask_all}};

    always @* begin
        inc_amount = {2'b00, soft_inc};
        for (i = 0; i < 4; i = i + 1) begin
            inc_amount = inc_amount + {2'b00, edge_hit[i]};
        end
    end
endmodule

// ===== core/cfsc_regs.v
// Purpose: per-channel edge error status, accumulated fails, fail counter
// Assumes: register bank port already retimed to clk_sys by the bus logic
// Notes:   read data is returned one clock after the read strobe
`timescale 1ns/1ps
`include "cfsc_defs.vh"
module cfsc_regs #(
    parameter ADDR_W = `CFSC_ADDR_W,
    parameter DATA_W = `CFSC_DATA_W
) (
    // clock and reset
    input  wire              clk_sys,
    input  wire              rst_n,
    // register bank port
    input  wire              bank_sel,
    input  wire              bank_write,
    input  wire [ADDR_W-1:0] bank_addr,
    input  wire [DATA_W-1:0] bank_wr_data,
    output wire [DATA_W-1:0] bank_rd_data,
    output wire              bank_rd_valid,
    // edge error toggles from the fast edge clock domain
    input  wire              reload_err_tgl,
    input  wire              order_err_tgl,
    input  wire              same_edge_err_tgl,
    input  wire              residue_ovf_tgl,
    input  wire              cal_ovf_tgl,
    input  wire              drive_close_tgl,
    input  wire              compare_close_tgl,
    // fail strobes, index 0 is first_edge .. 3 is fourth_edge
    input  wire [3:0]        edge_fail,
    input  wire [3:0]        window_fail,
    input  wire [3:0]        pattern_fail_mask,
    // configuration out
    output wire [3:0]        static_setup,
    output wire              fail_mask_on
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wire [`CFSC_ERR_SRC_N-1:0] err_tgl;
    wire [`CFSC_ERR_SRC_N-1:0] err_pulse;
    wire [3:0]                 edge_hit;
    wire [2:0]                 inc_amount;
    wire                       acc_rd;
    wire                       acc_wr;
    wire                       soft_inc;
    wire                       hit_cnt_low;
    wire                       hit_cnt_high;
    wire                       hit_static;
    wire                       hit_dynamic;
    wire                       low_rd;
    wire                       low_wr;
    wire                       high_wr;
    wire                       static_wr;
    wire                       dynamic_wr;
    wire [`CFSC_CNT_W-1:0]     inc_ext;

    reg                        reload_err_q;
    reg                        order_err_q;
    reg                        ovf_err_q;
    reg                        close_err_q;
    reg  [3:0]                 acc_fail_q;
    reg  [`CFSC_CNT_W-1:0]     count_q;
    reg  [`CFSC_CNT_W-1:0]     count_d;
    reg  [`CFSC_CNT_W-1:0]     hold_q;
    reg  [3:0]                 static_q;
    reg                        mask_q;
    reg  [DATA_W-1:0]          rd_data_q;
    reg  [DATA_W-1:0]          rd_data_d;
    reg                        rd_valid_q;

    assign err_tgl[`CFSC_SRC_RELOAD]    = reload_err_tgl;
    assign err_tgl[`CFSC_SRC_ORDER]     = order_err_tgl;
    assign err_tgl[`CFSC_SRC_SAME_EDGE] = same_edge_err_tgl;
    assign err_tgl[`CFSC_SRC_RES_OVF]   = residue_ovf_tgl;
    assign err_tgl[`CFSC_SRC_CAL_OVF]   = cal_ovf_tgl;
    assign err_tgl[`CFSC_SRC_DRV_CLOSE] = drive_close_tgl;
    assign err_tgl[`CFSC_SRC_CMP_CLOSE] = compare_close_tgl;

    // ------------------------------------------------------------------
    // crossing of edge error events
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CFSC_ERR_SRC_N; g = g + 1) begin : g_sync
            cfsc_pulse_sync u_sync (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .tgl_async (err_tgl[g]),
                .evt_pulse (err_pulse[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    // one access per selected clk_sys cycle
    assign acc_rd       = bank_sel & ~bank_write;
    assign acc_wr       = bank_sel & bank_write;
    assign hit_cnt_low  = (bank_addr == `CFSC_OFS_CNT_LOW);
    assign hit_cnt_high = (bank_addr == `CFSC_OFS_CNT_HIGH);
    assign hit_static   = (bank_addr == `CFSC_OFS_STATIC);
    assign hit_dynamic  = (bank_addr == `CFSC_OFS_DYNAMIC);

    // ------------------------------------------------------------------
    // per-register strobes
    // ------------------------------------------------------------------
    // status has no write strobe, it is read-only
    assign low_rd       = acc_rd & hit_cnt_low;
    assign low_wr       = acc_wr & hit_cnt_low;
    assign high_wr      = acc_wr & hit_cnt_high;
    assign static_wr    = acc_wr & hit_static;
    assign dynamic_wr   = acc_wr & hit_dynamic;
    // write of one is a single pulse
    assign soft_inc     = dynamic_wr & bank_wr_data[`CFSC_DYN_INC_BIT];

    // ------------------------------------------------------------------
    // fail gating and per-period increment
    // ------------------------------------------------------------------
    // dynamic mask bit gates fails
    cfsc_fail_add u_fail_add (
        .edge_fail         (edge_fail),
        .window_fail       (window_fail),
        .pattern_fail_mask (pattern_fail_mask),
        .fail_mask_all     (mask_q),
        .soft_inc          (soft_inc),
        .edge_hit          (edge_hit),
        .inc_amount        (inc_amount)
    );

    // ------------------------------------------------------------------
    // sticky edge error and accumulated fail bits
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reload_err_q <= 1'b0;
            order_err_q  <= 1'b0;
            ovf_err_q    <= 1'b0;
            close_err_q  <= 1'b0;
            acc_fail_q   <= 4'h0;
        end else begin
            if (err_pulse[`CFSC_SRC_RELOAD]) begin
                reload_err_q <= 1'b1;
            end
            if (err_pulse[`CFSC_SRC_ORDER] | err_pulse[`CFSC_SRC_SAME_EDGE]) begin
                order_err_q <= 1'b1;
            end
            if (err_pulse[`CFSC_SRC_RES_OVF] | err_pulse[`CFSC_SRC_CAL_OVF]) begin
                ovf_err_q <= 1'b1;
            end
            if (err_pulse[`CFSC_SRC_DRV_CLOSE] | err_pulse[`CFSC_SRC_CMP_CLOSE]) begin
                close_err_q <= 1'b1;
            end
            acc_fail_q[0] <= acc_fail_q[0] | edge_hit[0];
            acc_fail_q[1] <= acc_fail_q[1] | edge_hit[1];
            acc_fail_q[2] <= acc_fail_q[2] | edge_hit[2];
            acc_fail_q[3] <= acc_fail_q[3] | edge_hit[3];
        end
    end

    // ------------------------------------------------------------------
    // fail counter next value
    // ------------------------------------------------------------------
    // add up to four fails plus the soft increment
    assign inc_ext = {{(`CFSC_CNT_W-3){1'b0}}, inc_amount};

    always @* begin
        count_d = count_q + inc_ext;
        if (high_wr) begin
            count_d = {bank_wr_data, hold_q[DATA_W-1:0]};
        end
    end

    // ------------------------------------------------------------------
    // counter and holding register
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= `CFSC_RST_CNT;
            hold_q  <= `CFSC_RST_CNT;
        end else begin
            count_q <= count_d;
            if (low_rd) begin
                hold_q <= count_q;
            end
            if (low_wr) begin
                hold_q[DATA_W-1:0] <= bank_wr_data;
            end
            if (high_wr) begin
                hold_q[`CFSC_CNT_W-1:DATA_W] <= bank_wr_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // static and dynamic configuration
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            static_q <= `CFSC_RST_STATIC;
            mask_q   <= `CFSC_RST_MASK;
        end else begin
            if (static_wr) begin
                static_q <= bank_wr_data[`CFSC_STATIC_W-1:0];
            end
            if (dynamic_wr) begin
                mask_q <= bank_wr_data[`CFSC_DYN_MASK_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always @* begin
        rd_data_d = `CFSC_RST_DATA;
        if (acc_rd) begin
            case (bank_addr)
                `CFSC_OFS_STATUS: begin
                    rd_data_d[`CFSC_ST_RELOAD_BIT]                 = reload_err_q;
                    rd_data_d[`CFSC_ST_ORDER_BIT]                  = order_err_q;
                    rd_data_d[`CFSC_ST_OVF_BIT]                    = ovf_err_q;
                    rd_data_d[`CFSC_ST_CLOSE_BIT]                  = close_err_q;
                    rd_data_d[`CFSC_ST_FAIL_MSB:`CFSC_ST_FAIL_LSB] = acc_fail_q;
                end
                `CFSC_OFS_CNT_LOW: begin
                    rd_data_d = count_q[DATA_W-1:0];
                end
                `CFSC_OFS_CNT_HIGH: begin
                    rd_data_d = hold_q[`CFSC_CNT_W-1:DATA_W];
                end
                `CFSC_OFS_STATIC: begin
                    rd_data_d[`CFSC_STATIC_W-1:0] = static_q;
                end
                `CFSC_OFS_DYNAMIC: begin
                    // increment bit is a strobe and reads zero
                    rd_data_d[`CFSC_DYN_MASK_BIT] = mask_q;
                end
                default: begin
                    rd_data_d = `CFSC_RST_DATA;
                end
            endcase
        end
    end

    // zero when idle so banks can be OR'ed
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_q  <= `CFSC_RST_DATA;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= acc_rd;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign bank_rd_data  = rd_data_q;
    assign bank_rd_valid = rd_valid_q;
    assign static_setup  = static_q;
    assign fail_mask_on  = mask_q;
endmodule

// ===== bench/cfsc_regs_assertions.sv
// Purpose: port checks for the fail status and counter bank
// Assumes: read data stands one cycle after the read strobe
// Notes:   attached to every cfsc_regs by bind
`timescale 1ns/1ps
module cfsc_regs_chk (
    // watched ports
    input wire        clk_sys,
    input wire        rst_n,
    input wire        bank_sel,
    input wire        bank_write,
    input wire [4:0]  bank_addr,
    input wire [15:0] bank_wr_data,
    input wire [15:0] bank_rd_data,
    input wire        bank_rd_valid,
    input wire        reload_err_tgl,
    input wire [3:0]  static_setup,
    input wire        fail_mask_on
);
    reg  [4:0] addr_q;
    reg        tg_q;
    reg  [3:0] pipe_q;
    reg        rl_q;
    reg  [7:0] seen_q;
    wire       st_rd = bank_rd_valid && addr_q == 5'h00;
    wire       wr4   = bank_sel && bank_write && bank_addr == 5'h04;
    // ------------------------------------------------------------
    // reload event tracker and status history
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        addr_q <= bank_addr;
        tg_q   <= reload_err_tgl;
        if (!rst_n) begin
            pipe_q <= 4'h0;
            rl_q   <= 1'b0;
            seen_q <= 8'h00;
        end else begin
            pipe_q <= {pipe_q[2:0], reload_err_tgl != tg_q};
            rl_q   <= rl_q | pipe_q[3];
            seen_q <= st_rd ? (seen_q | bank_rd_data[7:0]) : seen_q;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    rd_follow_a: assert property (bank_sel && !bank_write |=> bank_rd_valid)
        else $error("read strobe without valid");
    rd_cause_a: assert property (bank_rd_valid |-> $past(bank_sel && !bank_write))
        else $error("valid without read strobe");
    idle_zero_a: assert property (!bank_rd_valid |-> bank_rd_data == 16'h0000)
        else $error("read data not zero when idle");
    status_upper_a: assert property (st_rd |-> bank_rd_data[15:8] == 8'h00)
        else $error("status upper byte not zero");
    status_sticky_a: assert property (st_rd |-> (bank_rd_data[7:0] & seen_q) == seen_q)
        else $error("status bit cleared");
    reload_flag_a: assert property (st_rd && rl_q |-> bank_rd_data[7])
        else $error("reload error not flagged");
    mask_write_a: assert property (wr4 |=> fail_mask_on == $past(bank_wr_data[2]))
        else $error("mask bit not written");
    mask_hold_a: assert property (!wr4 |=> $stable(fail_mask_on))
        else $error("mask bit changed unasked");
    setup_write_a: assert property (bank_sel && bank_write && bank_addr == 5'h03
        |=> static_setup == $past(bank_wr_data[3:0]))
        else $error("static setup not written");
    cover property (st_rd && bank_rd_data[7]);
    cover property (bank_sel && bank_write && bank_addr == 5'h02);
    cover property (wr4 && bank_wr_data[2]);
endmodule
bind cfsc_regs cfsc_regs_chk chk (.clk_sys, .rst_n, .bank_sel, .bank_write, .bank_addr,
    .bank_wr_data, .bank_rd_data, .bank_rd_valid, .reload_err_tgl, .static_setup,
    .fail_mask_on);

// ===== bench/cfsc_host_model.sv
// Purpose: host side of the register bank port
// Assumes: one strobe cycle per access, answer one cycle later
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ps
module cfsc_host_model (
    // clock
    input  wire        clk_sys,
    // register bank port
    output reg         bank_sel,
    output reg         bank_write,
    output reg  [4:0]  bank_addr,
    output reg  [15:0] bank_wr_data,
    input  wire [15:0] bank_rd_data,
    input  wire        bank_rd_valid
);
    initial begin
        bank_sel     = 1'b0;
        bank_write   = 1'b0;
        bank_addr    = 5'h00;
        bank_wr_data = 16'h0000;
    end
    task xfer(input w, input [4:0] a, input [15:0] d, output [15:0] q, output v);
        begin
            @(posedge clk_sys);
            #1;
            bank_sel     = 1'b1;
            bank_write   = w;
            bank_addr    = a;
            bank_wr_data = d;
            @(posedge clk_sys);
            #1;
            q            = bank_rd_data;
            v            = bank_rd_valid;
            bank_sel     = 1'b0;
            bank_addr    = ~a;
            bank_wr_data = ~d;
        end
    endtask
endmodule

// ===== bench/testbench.sv
// Purpose: self-checking bench for cfsc_regs
// Assumes: host model drives the bank port, bench drives event inputs
// Notes:   each scenario starts from a fresh reset
`timescale 1ns/1ps
`include "cfsc_defs.vh"
module testbench;
    reg         clk_sys;
    reg         rst_n;
    reg  [6:0]  tg;
    reg  [3:0]  ef;
    reg  [3:0]  wf;
    reg  [3:0]  pm;
    wire        bank_sel;
    wire        bank_write;
    wire [4:0]  bank_addr;
    wire [15:0] bank_wr_data;
    wire [15:0] bank_rd_data;
    wire        bank_rd_valid;
    wire [3:0]  static_setup;
    wire        fail_mask_on;
    integer     error_cnt;
    integer     checked;
    reg  [15:0] q;
    reg         v;
    localparam [20:0]  EB = {3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7};
    localparam [127:0] FT = {16'h0552, 16'hF0F4, 16'h0881, 16'h0221, 16'h8081,
                             16'h4041, 16'h2021, 16'h1011};
    cfsc_host_model host (.clk_sys(clk_sys), .bank_sel(bank_sel), .bank_write(bank_write),
        .bank_addr(bank_addr), .bank_wr_data(bank_wr_data), .bank_rd_data(bank_rd_data),
        .bank_rd_valid(bank_rd_valid));
    cfsc_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .bank_sel(bank_sel),
        .bank_write(bank_write), .bank_addr(bank_addr), .bank_wr_data(bank_wr_data),
        .bank_rd_data(bank_rd_data), .bank_rd_valid(bank_rd_valid), .reload_err_tgl(tg[0]),
        .order_err_tgl(tg[1]), .same_edge_err_tgl(tg[2]), .residue_ovf_tgl(tg[3]),
        .cal_ovf_tgl(tg[4]), .drive_close_tgl(tg[5]), .compare_close_tgl(tg[6]),
        .edge_fail(ef), .window_fail(wf), .pattern_fail_mask(pm),
        .static_setup(static_setup), .fail_mask_on(fail_mask_on));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rd(input [4:0] a, input [15:0] e);
        begin
            host.xfer(1'b0, a, 16'h0000, q, v);
            chk("rd_valid", v, 1);
            chk("rd_data", q, e);
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        host.xfer(1'b1, a, d, q, v);
    endtask
    task do_rst;
        begin
            @(posedge clk_sys);
            #1;
            rst_n = 1'b0;
            tg    = 7'h00;
            ef    = 4'h0;
            wf    = 4'h0;
            pm    = 4'h0;
            repeat (2) @(posedge clk_sys);
            #1;
            rst_n = 1'b1;
        end
    endtask
    task pulse(input [3:0] e, input [3:0] w);
        begin
            @(posedge clk_sys);
            #1;
            ef = e;
            wf = w;
            @(posedge clk_sys);
            #1;
            ef = 4'h0;
            wf = 4'h0;
        end
    endtask
    task t_regs;
        begin
            do_rst;
            rd(`CFSC_OFS_STATUS, 16'h0000);
            rd(`CFSC_OFS_CNT_LOW, 16'h0000);
            rd(`CFSC_OFS_CNT_HIGH, 16'h0000);
            rd(`CFSC_OFS_STATIC, 16'h0000);
            wr(5'h13, 16'hFFFF);
            rd(5'h13, 16'h0000);
            $display("t_regs done");
        end
    endtask
    task t_err;
        integer i;
        begin
            for (i = 0; i < 7; i = i + 1) begin
                do_rst;
                repeat (2) @(posedge clk_sys);
                #1;
                tg[i] = ~tg[i];
                repeat (6) @(posedge clk_sys);
                rd(`CFSC_OFS_STATUS, 16'h0001 << EB[3*i+:3]);
                rd(`CFSC_OFS_STATUS, 16'h0001 << EB[3*i+:3]);
            end
            $display("t_err done");
        end
    endtask
    task t_fail;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                do_rst;
                pulse(FT[16*i+12+:4], FT[16*i+8+:4]);
                rd(`CFSC_OFS_STATUS, {12'h000, FT[16*i+4+:4]});
                // low half first, then high half
                rd(`CFSC_OFS_CNT_LOW, {12'h000, FT[16*i+:4]});
                rd(`CFSC_OFS_CNT_HIGH, 16'h0000);
            end
            $display("t_fail done");
        end
    endtask
    task t_mask;
        begin
            do_rst;
            wr(`CFSC_OFS_DYNAMIC, 16'h0004);
            chk("fail_mask_on", fail_mask_on, 1);
            pulse(4'hF, 4'hF);
            rd(`CFSC_OFS_STATUS, 16'h0000);
            rd(`CFSC_OFS_CNT_LOW, 16'h0000);
            wr(`CFSC_OFS_DYNAMIC, 16'h0000);
            pm = 4'h1;
            pulse(4'h1, 4'h0);
            rd(`CFSC_OFS_STATUS, 16'h0000);
            pm = 4'h0;
            wr(`CFSC_OFS_DYNAMIC, 16'h0001);
            wr(`CFSC_OFS_DYNAMIC, 16'h0000);
            rd(`CFSC_OFS_CNT_LOW, 16'h0001);
            wr(`CFSC_OFS_STATIC, 16'hFFFF);
            chk("static_setup", static_setup, 4'hF);
            rd(`CFSC_OFS_STATIC, 16'h000F);
            $display("t_mask done");
        end
    endtask
    task t_cnt;
        begin
            do_rst;
            wr(`CFSC_OFS_CNT_LOW, 16'hFFFE);
            wr(`CFSC_OFS_CNT_HIGH, 16'h1234);
            rd(`CFSC_OFS_CNT_LOW, 16'hFFFE);
            pulse(4'hF, 4'h0);
            // live upper half is now 16'h1235, the snapshot still 16'h1234
            rd(`CFSC_OFS_CNT_HIGH, 16'h1234);
            rd(`CFSC_OFS_CNT_LOW, 16'h0002);
            pulse(4'hF, 4'h0);
            rd(`CFSC_OFS_CNT_HIGH, 16'h1235);
            rd(`CFSC_OFS_CNT_LOW, 16'h0006);
            wr(`CFSC_OFS_STATUS, 16'hFFFF);
            rd(`CFSC_OFS_STATUS, 16'h000F);
            $display("t_cnt done");
        end
    endtask
    task final_report;
        begin
            $display("checked %0d error_cnt %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        error_cnt = 0;
        checked   = 0;
        rst_n     = 1'b0;
        tg        = 7'h00;
        ef        = 4'h0;
        wf        = 4'h0;
        pm        = 4'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_regs;
        t_err;
        t_fail;
        t_mask;
        t_cnt;
        final_report;
    end
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule
